// ### smac_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module smac_cpu
(
	// Clock, reset and enable.
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	// User command port.
	input wire logic cmd_valid,
	input wire smac_pkg::smac_op_type cmd_op,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	input wire logic [7:0] cmd_data2,
	output logic cmd_ready,
	// Read answer.
	output logic [7:0] rsp_data,
	output logic rsp_valid,
	// Register bus towards the unit.
	smac_if.cpu bus
);

	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_SECOND,
		ST_GAP
	} smac_state_type;

	smac_state_type state_r;
	smac_state_type state_nxt;
	logic wr_r;
	logic wr_nxt;
	logic rd_r;
	logic rd_nxt;
	logic [7:0] addr_r;
	logic [7:0] addr_nxt;
	logic [7:0] wdata_r;
	logic [7:0] wdata_nxt;
	logic [7:0] second_r;
	logic [7:0] second_nxt;
	logic [7:0] rsp_data_r;
	logic [7:0] rsp_data_nxt;
	logic rsp_valid_r;
	logic rsp_valid_nxt;
	logic is_trig_addr;

	// An accumulate trigger address needs a following idle cycle.
	assign is_trig_addr = (cmd_addr == smac_pkg::ADDR_ACC_X_B1)
		|| (cmd_addr == smac_pkg::ADDR_ACC_Y_B0);
	assign cmd_ready = (state_r == ST_IDLE);

	// Sequencer for bus strobes and spacing.
	always_comb
	begin
		state_nxt = state_r;
		wr_nxt = 1'b0;
		rd_nxt = 1'b0;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		second_nxt = second_r;
		rsp_valid_nxt = bus.rvalid;
		rsp_data_nxt = bus.rvalid ? bus.rdata : rsp_data_r;
		case (state_r)
			ST_IDLE:
			begin
				if (cmd_valid)
				begin
					addr_nxt = cmd_addr;
					wdata_nxt = cmd_data;
					case (cmd_op)
						smac_pkg::OP_READ:
						begin
							rd_nxt = 1'b1;
						end
						smac_pkg::OP_WRITE:
						begin
							wr_nxt = 1'b1;
							if (is_trig_addr)
							begin
								state_nxt = ST_GAP;
							end
						end
						smac_pkg::OP_MAC:
						begin
							wr_nxt = 1'b1;
							addr_nxt = smac_pkg::ADDR_MULT_X;
							second_nxt = cmd_data2;
							state_nxt = ST_SECOND;
						end
						default: state_nxt = ST_IDLE;
					endcase
				end
			end
			ST_SECOND:
			begin
				wr_nxt = 1'b1;
				addr_nxt = smac_pkg::ADDR_ACC_Y_B0;
				wdata_nxt = second_r;
				state_nxt = ST_GAP;
			end
			ST_GAP:
			begin
				state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Registers, frozen while the clock enable is low.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r <= ST_IDLE;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			addr_r <= smac_pkg::RST_BYTE;
			wdata_r <= smac_pkg::RST_BYTE;
			second_r <= smac_pkg::RST_BYTE;
			rsp_data_r <= smac_pkg::RST_BYTE;
			rsp_valid_r <= 1'b0;
		end
		else if (clk_en)
		begin
			state_r <= state_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			second_r <= second_nxt;
			rsp_data_r <= rsp_data_nxt;
			rsp_valid_r <= rsp_valid_nxt;
		end
	end

	// Bus and answer outputs.
	assign bus.wr_en = wr_r;
	assign bus.rd_en = rd_r;
	assign bus.addr = addr_r;
	assign bus.wdata = wdata_r;
	assign rsp_data = rsp_data_r;
	assign rsp_valid = rsp_valid_r;

endmodule
`default_nettype wire

// ### smac_dev.sv
// Contract
// - All operands and results are signed.
// - Product and low accumulator bytes readable immediately.
// - Upper accumulator bytes valid one instruction later.
// - All locations decoded on the data bus.
// - Multiply-register write updates product only.
// - Accumulate-register write performs multiply-accumulate.
// - Either X write loads shared X.
// - Either Y write loads shared Y.
// - Clear register write zeroes accumulator.
// - Software loads first operand via multiply register.
// - Second operand to accumulate register triggers.
// - Operands are 8-bit signed values.
// - Product is 16-bit, high byte upper.
// - Accumulator 32-bit, byte 0 least significant.
// - Software spaces accumulate triggers by one instruction.
// - Accumulate X address reads accumulator byte 1.
// - Accumulate Y address reads accumulator byte 0.
// - Product high at EAh, low at EBh.
`timescale 1ns/1ps
`default_nettype none
module smac_dev
(
	// Clock, reset and enable.
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	// Register bus towards the CPU.
	smac_if.dev bus,
	// Observation of the accumulator.
	output logic [31:0] acc_value,
	output logic acc_busy
);

	// Operand, product and accumulator state.
	// signed 8-bit operands
	logic signed [7:0] op_x_r;
	logic signed [7:0] op_x_nxt;
	logic signed [7:0] op_y_r;
	logic signed [7:0] op_y_nxt;
	logic signed [15:0] prod_r;
	logic signed [15:0] prod_nxt;
	logic [15:0] acc_lo_r;
	logic [15:0] acc_lo_nxt;
	logic [15:0] acc_hi_r;
	logic [15:0] acc_hi_nxt;
	logic pend_r;
	logic pend_nxt;
	logic pend_carry_r;
	logic pend_carry_nxt;
	logic pend_ext_r;
	logic pend_ext_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic rvalid_r;
	logic rvalid_nxt;

	// Decoded strobes and arithmetic terms.
	logic wr_mult_x;
	logic wr_mult_y;
	logic wr_acc_x;
	logic wr_acc_y;
	logic wr_clear;
	logic trig;
	logic signed [15:0] prod_new;
	logic [16:0] lo_sum;

	// Write decode of the data bus.
	// bus address decode
	assign wr_mult_x = bus.wr_en && (bus.addr == smac_pkg::ADDR_MULT_X);
	assign wr_mult_y = bus.wr_en && (bus.addr == smac_pkg::ADDR_MULT_Y);
	assign wr_acc_x = bus.wr_en && (bus.addr == smac_pkg::ADDR_ACC_X_B1);
	assign wr_acc_y = bus.wr_en && (bus.addr == smac_pkg::ADDR_ACC_Y_B0);
	assign wr_clear = bus.wr_en
		&& ((bus.addr == smac_pkg::ADDR_CLR_A_B2) || (bus.addr == smac_pkg::ADDR_CLR_B_B3));
	assign trig = wr_acc_x || wr_acc_y;

	// Operand loading and product computed from the operands after this write.
	always_comb
	begin
		op_x_nxt = op_x_r;
		op_y_nxt = op_y_r;
		if (wr_mult_x || wr_acc_x)
		begin
			op_x_nxt = $signed(bus.wdata);
		end
		if (wr_mult_y || wr_acc_y)
		begin
			op_y_nxt = $signed(bus.wdata);
		end
		prod_new = 16'(op_x_nxt) * 16'(op_y_nxt);
		prod_nxt = prod_r;
		if (wr_mult_x || wr_mult_y || trig)
		begin
			prod_nxt = prod_new;
		end
	end

	// Two-step accumulation: low half at once, high half one cycle later.
	always_comb
	begin
		lo_sum = {1'b0, acc_lo_r} + {1'b0, prod_new};
		acc_lo_nxt = acc_lo_r;
		acc_hi_nxt = acc_hi_r;
		pend_nxt = 1'b0;
		pend_carry_nxt = pend_carry_r;
		pend_ext_nxt = pend_ext_r;
		if (pend_r)
		begin
			acc_hi_nxt = acc_hi_r + (pend_ext_r ? smac_pkg::HALF_ONES : smac_pkg::RST_HALF)
				+ {15'h0000, pend_carry_r};
		end
		if (trig)
		begin
			acc_lo_nxt = lo_sum[15:0];
			pend_nxt = 1'b1;
			pend_carry_nxt = lo_sum[16];
			pend_ext_nxt = prod_new[15];
		end
		if (wr_clear)
		begin
			acc_lo_nxt = smac_pkg::RST_HALF;
			acc_hi_nxt = smac_pkg::RST_HALF;
			pend_nxt = 1'b0;
		end
	end

	// Read multiplexer; data is returned one cycle after the read strobe.
	always_comb
	begin
		rvalid_nxt = bus.rd_en;
		rdata_nxt = rdata_r;
		if (bus.rd_en)
		begin
			case (bus.addr)
				smac_pkg::ADDR_PROD_HI: rdata_nxt = prod_r[15:8];
				smac_pkg::ADDR_PROD_LO: rdata_nxt = prod_r[7:0];
				smac_pkg::ADDR_ACC_X_B1: rdata_nxt = acc_lo_r[15:8];
				smac_pkg::ADDR_ACC_Y_B0: rdata_nxt = acc_lo_r[7:0];
				smac_pkg::ADDR_CLR_A_B2: rdata_nxt = acc_hi_r[7:0];
				smac_pkg::ADDR_CLR_B_B3: rdata_nxt = acc_hi_r[15:8];
				default: rdata_nxt = smac_pkg::UNMAPPED_DATA;
			endcase
		end
	end

	// State registers, frozen while the clock enable is low.
	// reset to zero
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			op_x_r <= smac_pkg::RST_BYTE;
			op_y_r <= smac_pkg::RST_BYTE;
			prod_r <= smac_pkg::RST_HALF;
			acc_lo_r <= smac_pkg::RST_HALF;
			acc_hi_r <= smac_pkg::RST_HALF;
			pend_r <= 1'b0;
			pend_carry_r <= 1'b0;
			pend_ext_r <= 1'b0;
			rdata_r <= smac_pkg::RST_BYTE;
			rvalid_r <= 1'b0;
		end
		else if (clk_en)
		begin
			op_x_r <= op_x_nxt;
			op_y_r <= op_y_nxt;
			prod_r <= prod_nxt;
			acc_lo_r <= acc_lo_nxt;
			acc_hi_r <= acc_hi_nxt;
			pend_r <= pend_nxt;
			pend_carry_r <= pend_carry_nxt;
			pend_ext_r <= pend_ext_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// Outputs.
	assign bus.rdata = rdata_r;
	assign bus.rvalid = rvalid_r;
	assign acc_value = {acc_hi_r, acc_lo_r};
	assign acc_busy = pend_r;

endmodule
`default_nettype wire

// ### smac_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smac_if;
	logic wr_en;
	logic rd_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;

	// The documented unit.
	modport dev
	(
		input wr_en, rd_en, addr, wdata,
		output rdata, rvalid
	);

	// The CPU side.
	modport cpu
	(
		output wr_en, rd_en, addr, wdata,
		input rdata, rvalid
	);
endinterface
`default_nettype wire

// ### smac_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module smac_monitor
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Register bus.
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	logic [7:0] x_r, y_r, nx, ny, exp_r, exp_nxt;
	logic signed [15:0] tp;
	logic [15:0] pr_r;
	logic [31:0] acc_r, acc_nxt;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// ----------------------------------------
	// Reference state
	// ----------------------------------------
	// Mirrors operands, product and accumulator from the writes seen on the bus.
	always_comb
	begin
		nx = (wr_en && (addr == 8'hE8 || addr == 8'hEC)) ? wdata : x_r;
		ny = (wr_en && (addr == 8'hE9 || addr == 8'hED)) ? wdata : y_r;
		tp = $signed(nx) * $signed(ny);
		acc_nxt = acc_r;
		if (wr_en && (addr == 8'hEC || addr == 8'hED))
			acc_nxt = acc_r + {{16{tp[15]}}, tp};
		if (wr_en && (addr == 8'hEE || addr == 8'hEF))
			acc_nxt = 32'h00000000;
		exp_nxt = exp_r;
		if (rd_en)
		begin
			case (addr)
				8'hEA: exp_nxt = pr_r[15:8];
				8'hEB: exp_nxt = pr_r[7:0];
				8'hEC: exp_nxt = acc_r[15:8];
				8'hED: exp_nxt = acc_r[7:0];
				8'hEE: exp_nxt = acc_r[23:16];
				8'hEF: exp_nxt = acc_r[31:24];
				default: exp_nxt = 8'h00;
			endcase
		end
	end

	// Registers the mirrored state; everything reads zero after reset.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			x_r <= 8'h00;
			y_r <= 8'h00;
			pr_r <= 16'h0000;
			acc_r <= 32'h00000000;
			exp_r <= 8'h00;
		end
		else
		begin
			x_r <= nx;
			y_r <= ny;
			pr_r <= tp;
			acc_r <= acc_nxt;
			exp_r <= exp_nxt;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_read(logic [7:0] a);
		rd_en && addr == a;
	endsequence

	property p_answer(logic [7:0] a);
		s_read(a) |=> rvalid && rdata == exp_r;
	endproperty

	a_prod_high: assert property (p_answer(8'hEA))
		else $error("Product high byte is wrong.");
	a_prod_low: assert property (p_answer(8'hEB))
		else $error("Product low byte is wrong.");
	a_acc_byte0: assert property (p_answer(8'hED))
		else $error("Accumulator byte 0 is wrong.");
	a_acc_byte1: assert property (p_answer(8'hEC))
		else $error("Accumulator byte 1 is wrong.");
	a_acc_byte2: assert property (p_answer(8'hEE))
		else $error("Accumulator byte 2 is wrong.");
	a_acc_byte3: assert property (p_answer(8'hEF))
		else $error("Accumulator byte 3 is wrong.");
	a_no_stray: assert property (rvalid |-> $past(rd_en))
		else $error("Read answer without a read.");
	a_trig_gap: assert property (wr_en && (addr == 8'hEC || addr == 8'hED) |=> !wr_en)
		else $error("Accumulate triggers back to back.");
endmodule
`default_nettype wire

// ### smac_pkg.sv
package smac_pkg;

	// Register addresses on the internal data bus.
	localparam logic [7:0] ADDR_MULT_X = 8'hE8;
	localparam logic [7:0] ADDR_MULT_Y = 8'hE9;
	localparam logic [7:0] ADDR_PROD_HI = 8'hEA;
	localparam logic [7:0] ADDR_PROD_LO = 8'hEB;
	localparam logic [7:0] ADDR_ACC_X_B1 = 8'hEC;
	localparam logic [7:0] ADDR_ACC_Y_B0 = 8'hED;
	localparam logic [7:0] ADDR_CLR_A_B2 = 8'hEE;
	localparam logic [7:0] ADDR_CLR_B_B3 = 8'hEF;

	// Widths and reset values.
	localparam int OPER_W = 8;
	localparam int PROD_W = 16;
	localparam int HALF_W = 16;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [15:0] HALF_ONES = 16'hFFFF;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;

	// Idle cycles the host inserts after an accumulate trigger.
	localparam int TRIG_GAP = 1;

	// Host user-side operations.
	typedef enum logic [1:0]
	{
		OP_READ,
		OP_WRITE,
		OP_MAC
	} smac_op_type;

endpackage

// ### tb_signed_multiply_accumulate.sv
`timescale 1ns/1ps
`default_nettype none
module tb_signed_multiply_accumulate;
	logic clk_sys, reset_n, clk_en, cmd_valid, cmd_ready, rsp_valid, acc_busy;
	smac_pkg::smac_op_type cmd_op;
	logic [7:0] cmd_addr, cmd_data, cmd_data2, rsp_data, x_m, y_m;
	logic [15:0] pr_m;
	logic [31:0] acc_value, acc_m;
	int bad_count, check_count, i;
	logic [7:0] xs [5] = '{8'hF6, 8'h80, 8'h80, 8'h7F, 8'hFF};
	logic [7:0] ys [5] = '{8'h07, 8'h80, 8'h7F, 8'h7F, 8'hFF};

	smac_if smac_if_inst ();
	smac_dev smac_dev_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
		.bus(smac_if_inst.dev), .acc_value(acc_value), .acc_busy(acc_busy));
	smac_cpu smac_cpu_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_data2(cmd_data2), .cmd_ready(cmd_ready), .rsp_data(rsp_data),
		.rsp_valid(rsp_valid), .bus(smac_if_inst.cpu));
	smac_monitor smac_monitor_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.wr_en(smac_if_inst.wr_en), .rd_en(smac_if_inst.rd_en), .addr(smac_if_inst.addr),
		.wdata(smac_if_inst.wdata), .rdata(smac_if_inst.rdata), .rvalid(smac_if_inst.rvalid));

	// Free-running 4 ns clock.
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic summarize();
		$display("Checks %0d, mismatches %0d.", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Issues one command on the user port, waiting a bounded time for ready.
	task automatic cmd(smac_pkg::smac_op_type op, logic [7:0] a, logic [7:0] d, logic [7:0] d2);
		int n;
		for (n = 0; n < 20 && cmd_ready !== 1'b1; n++)
			@(negedge clk_sys);
		if (n == 20)
		begin
			bad_count++;
			$display("CHECK FAILED cmd_ready expected 1 seen %b", cmd_ready);
			summarize();
		end
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		cmd_data2 = d2;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		// Let an edge pass so that a following call never re-raises the strobe at once.
		@(negedge clk_sys);
	endtask

	// Reads one register and compares it with the expected byte.
	task automatic rd(logic [7:0] a, logic [7:0] e);
		int n;
		cmd(smac_pkg::OP_READ, a, 8'h00, 8'h00);
		for (n = 0; n < 8 && rsp_valid !== 1'b1; n++)
			@(posedge clk_sys) #1;
		check_count++;
		if (n == 8 || rsp_data !== e)
		begin
			bad_count++;
			$display("CHECK FAILED reg %h expected %h seen %h", a, e, rsp_data);
			if (n == 8)
				summarize();
		end
		@(negedge clk_sys);
	endtask

	// Reference model of one register write.
	task automatic mdl(logic [7:0] a, logic [7:0] d);
		if (a == 8'hE8 || a == 8'hEC)
			x_m = d;
		if (a == 8'hE9 || a == 8'hED)
			y_m = d;
		pr_m = $signed(x_m) * $signed(y_m);
		if (a == 8'hEC || a == 8'hED)
			acc_m = acc_m + {{16{pr_m[15]}}, pr_m};
		if (a == 8'hEE || a == 8'hEF)
			acc_m = 32'h00000000;
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		mdl(a, d);
		cmd(smac_pkg::OP_WRITE, a, d, 8'h00);
	endtask

	task automatic mac(logic [7:0] x, logic [7:0] y);
		mdl(8'hE8, x);
		mdl(8'hED, y);
		cmd(smac_pkg::OP_MAC, 8'h00, x, y);
	endtask

	// Reads product and all accumulator bytes.
	task automatic chk();
		rd(8'hEA, pr_m[15:8]);
		rd(8'hEB, pr_m[7:0]);
		rd(8'hED, acc_m[7:0]);
		rd(8'hEC, acc_m[15:8]);
		rd(8'hEE, acc_m[23:16]);
		rd(8'hEF, acc_m[31:24]);
		check_count++;
		if (acc_value !== acc_m)
		begin
			bad_count++;
			$display("CHECK FAILED acc_value expected %h seen %h", acc_m, acc_value);
		end
		check_count++;
		if (acc_busy !== 1'b0)
		begin
			bad_count++;
			$display("CHECK FAILED acc_busy expected 0 seen %b", acc_busy);
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = smac_pkg::OP_READ;
		cmd_addr = 8'h00;
		cmd_data = 8'h00;
		cmd_data2 = 8'h00;
		x_m = 8'h00;
		y_m = 8'h00;
		pr_m = 16'h0000;
		acc_m = 32'h00000000;
		bad_count = 0;
		check_count = 0;
		repeat (16) @(negedge clk_sys);
		reset_n = 1'b1;
		@(negedge clk_sys);
		chk();
		rd(8'h10, 8'h00);
		$display("Test reset done.");
		for (i = 0; i < 5; i++)
		begin
			wr(8'hE8, xs[i]);
			wr(8'hE9, ys[i]);
			chk();
		end
		$display("Test multiply done.");
		for (i = 0; i < 5; i++)
		begin
			mac(xs[i], ys[i]);
			chk();
		end
		$display("Test accumulate done.");
		wr(8'hEC, 8'h05);
		wr(8'hE9, 8'hFD);
		wr(8'hEA, 8'h55);
		chk();
		wr(8'hED, 8'h03);
		check_count++;
		if (acc_busy !== 1'b1)
		begin
			bad_count++;
			$display("CHECK FAILED acc_busy expected 1 seen %b", acc_busy);
		end
		chk();
		$display("Test shared operands done.");
		// A clear offered while the clock enable is low must not be taken.
		clk_en = 1'b0;
		cmd(smac_pkg::OP_WRITE, 8'hEE, 8'h00, 8'h00);
		clk_en = 1'b1;
		chk();
		$display("Test clock enable done.");
		wr(8'hEE, 8'h0A);
		chk();
		mac(8'h80, 8'h7F);
		wr(8'hEF, 8'hFF);
		chk();
		$display("Test clear done.");
		mac(8'h7F, 8'h81);
		chk();
		reset_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		reset_n = 1'b1;
		x_m = 8'h00;
		y_m = 8'h00;
		pr_m = 16'h0000;
		acc_m = 32'h00000000;
		@(negedge clk_sys);
		chk();
		$display("Test reset in run done.");
		summarize();
	end
endmodule
`default_nettype wire
